// ==== scc_cmd_chk.sv ====
// command check, volume fan-out, status read-back and safety enable
// Summary of operation
// [R1] The host always sets at least one channel select bit in channel-addressed commands.
// [R2] A channel-addressed command with no channel selected is dropped with no effect.
// [R3] A volume command writes its level to every selected channel in the same cycle.
// [R4] The host holds serial input low while the read-back byte is clocked out.
// [R5] The host repeats an error read that returns zero while a status pin is high.
// [R6] The safety enable bit is zero after reset, safety function stopped.
// [R7] Writing one to the safety enable bit starts the safety function.
`timescale 1ns/100ps
`include "scc_regs.svh"
module scc_cmd_chk
    import scc_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int VOL_W    = 7
) (
    // clock and reset
    input  wire logic                        clk_sys_i,
    input  wire logic                        rstn_i,
    // decoded command bytes from the serial receiver
    input  wire logic                        byte_valid_i,
    input  wire logic [7:0]                  byte_i,
    input  wire logic                        si_i,
    // device state for read-back
    input  wire logic [7:0]                  status_i,
    input  wire logic [7:0]                  version_i,
    input  wire logic [7:0]                  error_i,
    input  wire logic [$clog2(CHANNELS)-1:0] vol_raddr_i,
    // results
    output logic      [7:0]                  rd_byte_o,
    output logic                             rd_valid_o,
    output logic                             rd_busy_o,
    output logic                             si_low_err_o,
    output logic                             safe_en_o,
    output logic                             fail_sel_o,
    output logic                             drop_o,
    output logic      [VOL_W-1:0]            vol_rdata_o
);
    scc_state_s_t s_q;
    scc_state_s_t s_d;
    scc_cmd_t     in_cmd;

    function automatic logic is_chan_cmd(input logic [3:0] op);
        return op == `SCC_OP_VOL;
    endfunction

    function automatic logic is_read_cmd(input logic [3:0] op);
        return op == `SCC_OP_RD_STAT || op == `SCC_OP_RD_VER || op == `SCC_OP_RD_ERR;
    endfunction

    assign in_cmd = scc_cmd_t'(byte_i);

    always_comb begin
        s_d            = s_q;
        s_d.rd_valid   = 1'b0;
        s_d.drop_pulse = 1'b0;
        s_d.vol_we     = 4'h0;
        unique case (s_q.st)
            SCC_IDLE: begin
                if (byte_valid_i) begin
                    s_d.cmd = in_cmd;
                    // [R2] empty channel field dropped
                    if (is_chan_cmd(in_cmd.op) && in_cmd.chan == `SCC_CH_NONE) begin
                        s_d.drop_pulse = 1'b1;
                        // keep the stored command, a drop leaves no trace
                        s_d.cmd        = s_q.cmd;
                    end else if (is_read_cmd(in_cmd.op)) begin
                        s_d.st         = SCC_READ;
                        s_d.rd_busy    = 1'b1;
                        s_d.si_low_err = 1'b0;
                        if (in_cmd.op == `SCC_OP_RD_STAT) begin
                            s_d.rd_byte = status_i;
                        end else if (in_cmd.op == `SCC_OP_RD_VER) begin
                            s_d.rd_byte = version_i;
                        end else begin
                            s_d.rd_byte = error_i;
                        end
                    end else if (in_cmd.op == `SCC_OP_SAFE) begin
                        // [R7] one starts safety function
                        s_d.safe_en = in_cmd.chan[0];
                    end else if (in_cmd.op == `SCC_OP_OUTSEL) begin
                        s_d.fail_sel = in_cmd.chan[0];
                    end else if (is_chan_cmd(in_cmd.op)) begin
                        s_d.st = SCC_ARG;
                    end
                end
            end
            SCC_ARG: begin
                if (byte_valid_i) begin
                    // [R3] level to all selected channels
                    s_d.vol_we = s_q.cmd.chan;
                    s_d.vol_wd = byte_i[6:0];
                    s_d.st     = SCC_IDLE;
                end
            end
            SCC_READ: begin
                // [R4] serial input must stay low
                if (si_i) begin
                    s_d.si_low_err = 1'b1;
                end
                if (byte_valid_i) begin
                    s_d.rd_valid = 1'b1;
                    s_d.rd_busy  = 1'b0;
                    s_d.st       = SCC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            s_q            <= '0;
            s_q.st         <= SCC_IDLE;
            // [R6] safety stopped at reset
            s_q.safe_en    <= `SCC_SAFE_RST;
            s_q.vol_wd     <= `SCC_VOL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    scc_vol_mem #(
        .CHANNELS (CHANNELS),
        .VOL_W    (VOL_W)
    ) u_vol (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .we_i      (s_q.vol_we[CHANNELS-1:0]),
        .wdata_i   (s_q.vol_wd[VOL_W-1:0]),
        .raddr_i   (vol_raddr_i),
        .rdata_o   (vol_rdata_o)
    );

    assign rd_byte_o    = s_q.rd_byte;
    assign rd_valid_o   = s_q.rd_valid;
    assign rd_busy_o    = s_q.rd_busy;
    assign si_low_err_o = s_q.si_low_err;
    assign safe_en_o    = s_q.safe_en;
    assign fail_sel_o   = s_q.fail_sel;
    assign drop_o       = s_q.drop_pulse;

    // checks
    // assertion helpers, read by nothing but the checks below
    logic empty_vol;
    logic safe_cmd;
    logic read_cmd;

    assign empty_vol = s_q.st == SCC_IDLE && byte_valid_i && is_chan_cmd(in_cmd.op)
                       && in_cmd.chan == `SCC_CH_NONE;
    assign safe_cmd  = s_q.st == SCC_IDLE && byte_valid_i && in_cmd.op == `SCC_OP_SAFE;
    assign read_cmd  = s_q.st == SCC_IDLE && byte_valid_i && is_read_cmd(in_cmd.op);

    // [R2] empty field dropped
    a_empty_chan_drop: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R2]
        (s_q.st == SCC_IDLE && byte_valid_i && in_cmd.op == `SCC_OP_VOL
         && in_cmd.chan == `SCC_CH_NONE) |=> (drop_o && s_q.st == SCC_IDLE && s_q.vol_we == 4'h0))
        else $error("empty channel command not dropped");

    // [R2] drop leaves state alone
    a_drop_no_effect: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R2]
        empty_vol
        |=> ($stable(safe_en_o) && $stable(fail_sel_o) && $stable(rd_byte_o)
             && $stable(s_q.cmd) && !rd_busy_o))
        else $error("dropped command changed device state");

    // [R2] drop only when empty
    a_drop_cause: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R2]
        drop_o |-> $past(empty_vol))
        else $error("drop pulse without an empty channel command");

    // [R3] level to selected channels
    a_vol_fan_out: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R3]
        (s_q.st == SCC_ARG && byte_valid_i)
        |=> (s_q.vol_we == $past(s_q.cmd.chan) && s_q.vol_wd == $past(byte_i[6:0])))
        else $error("volume not applied to all selected channels");

    // [R3] one write per level
    a_vol_one_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R3]
        (s_q.vol_we != 4'h0) |=> (s_q.vol_we == 4'h0))
        else $error("volume write enable held too long");

    // [R3] writes only from argument
    a_vol_we_origin: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R3]
        (s_q.vol_we != 4'h0) |-> ($past(s_q.st) == SCC_ARG))
        else $error("volume written outside the argument byte");

    // [R4] status byte captured
    a_read_capture: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R4]
        (read_cmd && in_cmd.op == `SCC_OP_RD_STAT)
        |=> (rd_byte_o == $past(status_i) && rd_busy_o))
        else $error("status byte not captured for read-back");

    // [R4] error byte captured
    a_err_capture: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R4]
        (read_cmd && in_cmd.op == `SCC_OP_RD_ERR) |=> (rd_byte_o == $past(error_i)))
        else $error("error byte not captured for read-back");

    // [R4] serial input watched
    a_si_low_flag: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R4]
        (s_q.st == SCC_READ && si_i) |=> si_low_err_o)
        else $error("high serial input during read not flagged");

    // [R4] flag fresh per read
    a_si_err_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R4]
        read_cmd |=> !si_low_err_o)
        else $error("serial input flag not cleared by a new read");

    // [R4] read ends on byte
    a_busy_release: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R4]
        (rd_busy_o && byte_valid_i) |=> (!rd_busy_o && rd_valid_o))
        else $error("read-back did not end on the returned byte");

    // [R6] safety stopped at reset
    a_safe_reset: assert property (@(posedge clk_sys_i) // [R6]
        !rstn_i |=> !safe_en_o)
        else $error("safety enable not cleared by reset");

    // [R7] one starts safety
    a_safe_start: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R7]
        (s_q.st == SCC_IDLE && byte_valid_i && in_cmd.op == `SCC_OP_SAFE && in_cmd.chan[0])
        |=> safe_en_o)
        else $error("safety function not started");

    // [R7] enable follows the bit
    a_safe_follow: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R7]
        safe_cmd |=> (safe_en_o == $past(byte_i[0])))
        else $error("safety enable does not follow the written bit");

    // [R7] enable moves only on command
    a_safe_only_cmd: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R7]
        !$stable(safe_en_o) |-> $past(safe_cmd))
        else $error("safety enable changed without a safety command");
endmodule

// ==== scc_regs.svh ====
// constants for the speech command channel status checks
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
`define SCC_OP_VOL        4'h1
`define SCC_OP_RD_STAT    4'h2
`define SCC_OP_RD_VER     4'h3
`define SCC_OP_RD_ERR     4'h4
`define SCC_OP_SAFE       4'h5
`define SCC_OP_OUTSEL     4'h6
`define SCC_CH_NONE       4'h0
`define SCC_VOL_RST       7'h00
`define SCC_SAFE_RST      1'b0
`define SCC_OUTSEL_FAIL   1'b1
`define SCC_VOL_ADDR_W    2
`endif

// ==== scc_pkg.sv ====
// types for the speech command channel status checks
package scc_pkg;
    typedef enum logic [1:0] {
        SCC_IDLE,
        SCC_ARG,
        SCC_READ
    } scc_state_t;

    typedef struct packed {
        logic [3:0] op;
        logic [3:0] chan;
    } scc_cmd_t;

    typedef struct packed {
        scc_state_t st;
        scc_cmd_t   cmd;
        logic [7:0] rd_byte;
        logic       rd_valid;
        logic       rd_busy;
        logic       si_low_err;
        logic       safe_en;
        logic       fail_sel;
        logic       drop_pulse;
        logic [3:0] vol_we;
        logic [6:0] vol_wd;
    } scc_state_s_t;
endpackage

// ==== scc_vol_mem.sv ====
// per-channel volume store, registered read
`timescale 1ns/100ps
module scc_vol_mem #(
    parameter int CHANNELS = 4,
    parameter int VOL_W    = 7
) (
    // clock and reset
    input  wire logic                        clk_sys_i,
    input  wire logic                        rstn_i,
    // write side, one enable per channel
    input  wire logic [CHANNELS-1:0]         we_i,
    input  wire logic [VOL_W-1:0]            wdata_i,
    // read side
    input  wire logic [$clog2(CHANNELS)-1:0] raddr_i,
    output logic      [VOL_W-1:0]            rdata_o
);
    logic [VOL_W-1:0] mem_q [CHANNELS];

    always_ff @(posedge clk_sys_i) begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (!rstn_i) begin
                mem_q[i] <= VOL_W'(0);
            end else if (we_i[i]) begin
                mem_q[i] <= wdata_i;
            end
        end
        if (!rstn_i) begin
            rdata_o <= VOL_W'(0);
        end else begin
            rdata_o <= mem_q[raddr_i];
        end
    end
endmodule

// ==== scc_host.sv ====
// host model driving the serial command bytes
`timescale 1ns/100ps
module scc_host (
    // clock
    input  wire logic       clk_sys_i,
    // command byte stream
    output logic            byte_valid_o,
    output logic [7:0]      byte_o,
    output logic            si_o
);
    initial begin
        byte_valid_o = 1'b0;
        byte_o = 8'h00;
        si_o = 1'b1;
    end
    // callers pass a nonzero channel field in volume commands unless a drop is wanted
    task automatic send(input logic [7:0] b);
        @(posedge clk_sys_i);
        byte_valid_o <= 1'b1;
        byte_o <= b;
        @(posedge clk_sys_i);
        byte_valid_o <= 1'b0;
        byte_o <= ~b;
    endtask
    task automatic read(input logic [3:0] op, input logic si_lvl);
        send({op, 4'h0});
        // serial input held at si_lvl for the returned byte
        si_o <= si_lvl;
        send(8'h00);
        si_o <= 1'b1;
    endtask
endmodule

// ==== scc_cmd_chk_tb.sv ====
// self-checking bench for the command check block
`timescale 1ns/100ps
`include "scc_regs.svh"
module scc_cmd_chk_tb;
    logic       clk_sys_i;
    logic       rstn_i;
    logic       bv;
    logic       si;
    logic [7:0] bt;
    logic [7:0] rd_byte;
    logic [7:0] err_v;
    logic       rd_valid;
    logic       busy;
    logic       si_err;
    logic       safe_en;
    logic       fail_sel;
    logic       drop;
    logic [1:0] raddr;
    logic [6:0] vol;
    int         err_count;
    int         checked;
    int         n_rd = 0;
    int         n_busy = 0;
    scc_host i_host (.clk_sys_i(clk_sys_i), .byte_valid_o(bv), .byte_o(bt), .si_o(si));
    scc_cmd_chk i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .byte_valid_i(bv), .byte_i(bt),
        .si_i(si), .status_i(8'h5a), .version_i(8'hc3), .error_i(err_v), .vol_raddr_i(raddr),
        .rd_byte_o(rd_byte), .rd_valid_o(rd_valid), .rd_busy_o(busy), .si_low_err_o(si_err),
        .safe_en_o(safe_en), .fail_sel_o(fail_sel), .drop_o(drop), .vol_rdata_o(vol));
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // pulse counter, sampled before the edge's own updates
    always @(posedge clk_sys_i) if (rd_valid === 1'b1) n_rd++;
    always @(posedge clk_sys_i) if (busy === 1'b1) n_busy++;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic t_safe;
        #1 chk(safe_en, 1'b0);
        i_host.send({`SCC_OP_SAFE, 4'h1});
        @(posedge clk_sys_i);
        #1 chk(safe_en, 1'b1);
        // reset in mid-run must stop the safety function again
        @(posedge clk_sys_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        #1 chk(safe_en, 1'b0);
        $display("t_safe done");
    endtask
    task automatic t_drop;
        logic seen;
        seen = 1'b0;
        i_host.send({`SCC_OP_VOL, `SCC_CH_NONE});
        // bounded wait, a missing pulse fails the check
        repeat (3) begin
            #1 if (drop === 1'b1) seen = 1'b1;
            @(posedge clk_sys_i);
        end
        chk(seen, 1'b1);
        chk(busy, 1'b0);
        $display("t_drop done");
    endtask
    task automatic t_vol;
        i_host.send({`SCC_OP_VOL, 4'ha});
        i_host.send(8'h2a);
        repeat (3) @(posedge clk_sys_i);
        for (int c = 0; c < 4; c++) begin
            @(posedge clk_sys_i);
            raddr <= c[1:0];
            repeat (2) @(posedge clk_sys_i);
            #1 chk({1'b0, vol}, c[0] ? 8'h2a : 8'h00);
        end
        $display("t_vol done");
    endtask
    task automatic t_read;
        logic [7:0] exp [3];
        logic [3:0] op [3];
        int n0;
        int b0;
        exp = '{8'h5a, 8'hc3, 8'h81};
        op = '{`SCC_OP_RD_STAT, `SCC_OP_RD_VER, `SCC_OP_RD_ERR};
        for (int k = 0; k < 3; k++) begin
            n0 = n_rd;
            b0 = n_busy;
            i_host.read(op[k], 1'b0);
            repeat (2) @(posedge clk_sys_i);
            #1 chk(rd_byte, exp[k]);
            chk(8'(n_rd - n0), 8'h01);
            chk(8'(n_busy - b0), 8'h02);
            chk(si_err, 1'b0);
        end
        // host slip: serial input left high
        i_host.read(`SCC_OP_RD_STAT, 1'b1);
        repeat (2) @(posedge clk_sys_i);
        #1 chk(si_err, 1'b1);
        $display("t_read done");
    endtask
    task automatic t_retry;
        int n0;
        i_host.send({`SCC_OP_OUTSEL, 4'h1});
        err_v <= 8'h00;
        repeat (2) @(posedge clk_sys_i);
        #1 chk(fail_sel, 1'b1);
        n0 = n_rd;
        i_host.read(`SCC_OP_RD_ERR, 1'b0);
        repeat (2) @(posedge clk_sys_i);
        // all-low error byte with a status pin high: read again
        if (fail_sel === 1'b1 && rd_byte === 8'h00) i_host.read(`SCC_OP_RD_ERR, 1'b0);
        repeat (2) @(posedge clk_sys_i);
        #1 chk(8'(n_rd - n0), 8'h02);
        $display("t_retry done");
    endtask
    initial begin
        rstn_i = 1'b0;
        raddr = 2'h0;
        err_v = 8'h81;
        err_count = 0;
        checked = 0;
        repeat (6) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(posedge clk_sys_i);
        t_safe();
        t_drop();
        t_vol();
        t_read();
        t_retry();
        tally_and_finish();
    end
endmodule
